// *** fcsc_scanner.sv ***
// flash checksum scanner: registers, scan engine, fault interrupt and debug handling
//
// Contract
// - a checksum mismatch clears the pass flag; this or a debugger pass flag write zero raises the fault interrupt
// - fault interrupt enable is set by writing one, cleared only by system reset
// - pass flag cleared with enable set raises interrupt, held until system reset
// - the fault interrupt ignores the processor global interrupt enable
// - scanning halts while the processor sleeps and resumes on wake-up
// - scan starts three cycles after enable; sleep there defers scan and handlers
// - debugger access halts scanner; internal access or disconnect restarts the scan
// - busy keeps reading one during debugger halt, but nothing is checked
// - debugger busy write zero aborts; one schedules one check after release
// - while busy, section select and interrupt enable writes have no effect
// - debugger pass flag write zero raises interrupt; afterwards all writes ignored
// - debugger pass flag write one reads as one while not busy
// - control bit 7 strobe clears all registers one cycle later, except interrupt enable bit
// - reset strobe acts anytime without interrupt enable, only when idle with it
// - setting the interrupt enable only takes effect when not busy
// - enable write one starts a check; bit stays one; rewriting one restarts
// - enable write zero stops after the current section; its failure still counts
// - section register ignores writes when busy or after interrupt; control after it
// - section field: whole flash, boot plus application, boot only, reserved
// - after a startup scan enable reads one and section shows the checked one
// - pass flag is one after reset, clears on enable, reads zero while busy
// - busy reads one while scanning; status is read-only to processor software
// - checksum preset to all ones each scan, updated per byte with CCITT
// - bytes ascend from the section start, each shifted in most significant first
// - scanner owns flash over the processor and fetches one word every third cycle
//
// Chosen here: the Avalon-MM slave port.
`default_nettype none
module fcsc_scanner
  import fcsc_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    rst_i,
  // avalon-mm slave
  input  wire logic [FCSC_ADDR_W-1:0]  avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [FCSC_DATA_W-1:0]  avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output var  logic [FCSC_DATA_W-1:0]  avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // debugger
  input  wire logic                    dbg_write_i,
  input  wire logic                    dbg_access_i,
  input  wire logic                    dbg_internal_i,
  input  wire logic                    dbg_disconnect_i,
  // processor state
  input  wire logic                    sleep_i,
  output logic                         cpu_stall_o,
  output logic                         irq_defer_o,
  output logic                         nmi_o,
  // startup scan result
  input  wire logic                    startup_load_i,
  input  wire logic [1:0]              startup_src_i,
  input  wire logic                    startup_ok_i,
  // section limits as last word addresses
  input  wire logic [FCSC_FADDR_W-1:0] flash_last_i,
  input  wire logic [FCSC_FADDR_W-1:0] app_last_i,
  input  wire logic [FCSC_FADDR_W-1:0] boot_last_i,
  // program flash
  output fcsc_flash_req_t              flash_o,
  input  wire logic [15:0]             flash_rdata_i
);

  // one byte into the checksum, most significant bit first
  function automatic logic [15:0] fcsc_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data[i];
      c  = {c[14:0], 1'b0} ^ (fb ? FCSC_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  fcsc_state_t             state_r;
  logic [1:0]              dly_cnt_r;
  logic [1:0]              phase_r;
  logic [FCSC_FADDR_W-1:0] waddr_r;
  logic [15:0]             crc_r;
  logic [7:0]              hbyte_r;
  logic                    enable_r;
  logic                    fault_nmi_enable_r;
  logic [1:0]              src_r;
  logic                    ok_r;
  logic                    single_r;
  logic                    dbg_hold_r;
  logic                    defer_r;
  logic                    nmi_r;
  logic                    rst_pend_r;
  logic                    ack_r;

  // bus decode; a word address with low bits set is unmapped
  wire       bus_req   = avs_read_i | avs_write_i;
  wire [1:0] reg_idx   = avs_address_i[3:2];
  wire       addr_ok   = (avs_address_i[1:0] == 2'h0);
  wire [7:0] wbyte     = avs_writedata_i[7:0];
  // all writes locked once the fault interrupt has fired
  wire       wr_ok     = avs_write_i & ack_r & avs_byteenable_i[0] & addr_ok & ~nmi_r;
  wire       busy      = (state_r != FCSC_S_IDLE);
  wire       wr_ctrl   = wr_ok & (reg_idx == FCSC_IDX_CTRL);
  wire       wr_src    = wr_ok & (reg_idx == FCSC_IDX_SRC) & ~busy;
  // processor software cannot write status; only the debugger can
  wire       wr_stat   = wr_ok & (reg_idx == FCSC_IDX_STATUS) & dbg_write_i;
  wire       start_req = wr_ctrl & wbyte[FCSC_CTRL_ENABLE];
  wire       fault_nmi_enable_set = wr_ctrl & wbyte[FCSC_CTRL_FAULT_NMI_ENABLE] & ~busy;
  wire       rst_req   = wr_ctrl & wbyte[FCSC_CTRL_RESET] & (~fault_nmi_enable_r | ~busy);
  wire       dbg_abort = wr_stat & ~wbyte[FCSC_STAT_BUSY];
  wire       dbg_start = wr_stat & wbyte[FCSC_STAT_BUSY] & ~busy;
  wire       dbg_okclr = wr_stat & ~wbyte[FCSC_STAT_OK];
  wire       dbg_okset = wr_stat & wbyte[FCSC_STAT_OK] & ~busy;

  // scan engine controls
  wire       halt      = sleep_i | dbg_hold_r;
  wire       dbg_rel   = dbg_hold_r & (dbg_internal_i | dbg_disconnect_i);
  wire       restart   = dbg_rel & busy;
  wire       run       = (state_r == FCSC_S_SCAN) & ~halt;
  wire       dly_done  = (state_r == FCSC_S_DELAY) & ~sleep_i & (dly_cnt_r == FCSC_START_DLY - 2'h1);

  // section end address; the reserved code falls back to the whole flash
  wire [FCSC_FADDR_W-1:0] sec_last =
      (src_r == FCSC_SEC_BOOT)    ? boot_last_i :
      (src_r == FCSC_SEC_BOOT_AND_APP_SECTIONS) ? app_last_i  : flash_last_i;

  // checksum datapath: low byte (lower address) at phase 1, high byte at phase 2
  wire [15:0] crc_lo   = fcsc_crc_byte(crc_r, flash_rdata_i[7:0]);
  wire [15:0] crc_hi   = fcsc_crc_byte(crc_r, hbyte_r);
  wire        word_end = run & (phase_r == FCSC_FETCH_LAST);
  // a fetch already issued is absorbed even if a halt arrives, since its data is gone after
  wire        fetch_due = (state_r == FCSC_S_SCAN) & (phase_r == 2'h1);
  // stored checksum is appended high byte first, so a clean section leaves a zero residue
  wire        sec_end  = word_end & (waddr_r == sec_last);
  wire        sec_pass = (crc_hi == FCSC_CRC_GOOD);
  wire        sec_fail = sec_end & ~sec_pass;
  wire        again    = enable_r & ~single_r;
  wire        fail_evt = sec_fail | dbg_okclr;

  // bus handshake: every request answered on the second edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  assign avs_waitrequest_o = bus_req & ~ack_r;

  // read data registered so it stands at the acknowledging edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i & ~ack_r) begin
      avs_readdata_o <= '0;
      if (addr_ok) begin
        unique case (reg_idx)
          FCSC_IDX_CTRL:   avs_readdata_o[7:0] <= {6'h00, fault_nmi_enable_r, enable_r};
          FCSC_IDX_SRC:    avs_readdata_o[7:0] <= {6'h00, src_r};
          FCSC_IDX_STATUS: avs_readdata_o[7:0] <= {6'h00, ok_r & ~busy, busy};
          default:         avs_readdata_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // strobe delay: registers clear one cycle after the reset bit write
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rst_pend_r <= 1'b0;
    end else begin
      rst_pend_r <= rst_req;
    end
  end

  // interrupt enable: set-only, only system reset clears it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      fault_nmi_enable_r <= FCSC_CTRL_RST[FCSC_CTRL_FAULT_NMI_ENABLE];
    end else if (fault_nmi_enable_set) begin
      fault_nmi_enable_r <= 1'b1;
    end
  end

  // fault interrupt: sticky until system reset, independent of processor masking
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      nmi_r <= 1'b0;
    end else if (fail_evt & fault_nmi_enable_r) begin
      nmi_r <= 1'b1;
    end
  end

  assign nmi_o = nmi_r;

  // enable bit and section select
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      enable_r <= FCSC_CTRL_RST[FCSC_CTRL_ENABLE];
      src_r    <= FCSC_SRC_RST[1:0];
    end else if (rst_pend_r) begin
      enable_r <= 1'b0;
      src_r    <= 2'h0;
    end else if (startup_load_i) begin
      enable_r <= 1'b1;
      src_r    <= startup_src_i;
    end else begin
      if (wr_ctrl) begin
        enable_r <= wbyte[FCSC_CTRL_ENABLE];
      end
      if (wr_src) begin
        src_r <= wbyte[1:0];
      end
    end
  end

  // pass flag; a fail in the same cycle as a set always wins
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ok_r <= FCSC_STATUS_RST[FCSC_STAT_OK];
    end else if (rst_pend_r) begin
      ok_r <= 1'b0;
    end else if (fail_evt) begin
      ok_r <= 1'b0;
    end else if (startup_load_i) begin
      ok_r <= startup_ok_i;
    end else if (start_req) begin
      ok_r <= 1'b0;
    end else if (sec_end | dbg_okset) begin
      ok_r <= 1'b1;
    end
  end

  // debugger hold: any access halts, internal access or disconnect releases
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dbg_hold_r <= 1'b0;
    end else if (dbg_access_i) begin
      dbg_hold_r <= 1'b1;
    end else if (dbg_internal_i | dbg_disconnect_i) begin
      dbg_hold_r <= 1'b0;
    end
  end

  // interrupt deferral when sleep is entered during the start delay
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      defer_r <= 1'b0;
    end else if (rst_pend_r | dbg_abort | (sec_end & ~again)) begin
      defer_r <= 1'b0;
    end else if (sec_end) begin
      defer_r <= 1'b0;
    end else if ((state_r == FCSC_S_DELAY) & sleep_i) begin
      defer_r <= 1'b1;
    end
  end

  assign irq_defer_o = defer_r;

  // scan sequencer
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r   <= FCSC_S_IDLE;
      dly_cnt_r <= 2'h0;
      single_r  <= 1'b0;
    end else if (rst_pend_r | dbg_abort) begin
      state_r   <= FCSC_S_IDLE;
      single_r  <= 1'b0;
    end else if (start_req) begin
      state_r   <= FCSC_S_DELAY;
      dly_cnt_r <= 2'h0;
      single_r  <= 1'b0;
    end else if (dbg_start) begin
      state_r   <= FCSC_S_SCAN;
      single_r  <= 1'b1;
    end else begin
      unique case (state_r)
        FCSC_S_IDLE: begin
          dly_cnt_r <= 2'h0;
        end
        FCSC_S_DELAY: begin
          if (dly_done) begin
            state_r <= FCSC_S_SCAN;
          end else if (~sleep_i) begin
            dly_cnt_r <= dly_cnt_r + 2'h1;
          end
        end
        FCSC_S_SCAN: begin
          if (sec_end) begin
            state_r  <= again ? FCSC_S_SCAN : FCSC_S_IDLE;
            single_r <= 1'b0;
          end
        end
        default: begin
          state_r <= FCSC_S_IDLE;
        end
      endcase
    end
  end

  // fetch pacing and checksum: one word every third cycle while running
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      phase_r <= 2'h0;
      waddr_r <= '0;
      crc_r   <= FCSC_CRC_INIT;
      hbyte_r <= 8'h00;
    end else if ((state_r != FCSC_S_SCAN) | restart | sec_end) begin
      phase_r <= 2'h0;
      waddr_r <= '0;
      crc_r   <= FCSC_CRC_INIT;
    end else if (run | fetch_due) begin
      unique case (phase_r)
        2'h0: begin
          phase_r <= 2'h1;
        end
        2'h1: begin
          crc_r   <= crc_lo;
          hbyte_r <= flash_rdata_i[15:8];
          phase_r <= 2'h2;
        end
        default: begin
          crc_r   <= crc_hi;
          waddr_r <= waddr_r + FCSC_FADDR_W'(1);
          phase_r <= 2'h0;
        end
      endcase
    end
  end

  // flash request issued in the first cycle of each fetch slot
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      flash_o <= '0;
    end else begin
      flash_o.req  <= run & (phase_r == 2'h0) & ~restart & ~dbg_abort & ~rst_pend_r;
      flash_o.addr <= waddr_r;
    end
  end

  // processor stalled while the scanner owns the flash
  assign cpu_stall_o = run;

endmodule
`default_nettype wire

// *** fcsc_pkg.sv ***
// package of constants and types for the flash checksum scanner
`default_nettype none
package fcsc_pkg;
  // register indices; byte address is four times the index
  localparam logic [1:0]  FCSC_IDX_CTRL    = 2'h0;
  localparam logic [1:0]  FCSC_IDX_SRC     = 2'h1;
  localparam logic [1:0]  FCSC_IDX_STATUS  = 2'h2;
  localparam int          FCSC_ADDR_W      = 4;
  localparam int          FCSC_DATA_W      = 32;
  // scan_control fields
  localparam int          FCSC_CTRL_ENABLE = 0;
  localparam int          FCSC_CTRL_FAULT_NMI_ENABLE  = 1;
  localparam int          FCSC_CTRL_RESET  = 7;
  // scan_result_status fields
  localparam int          FCSC_STAT_BUSY   = 0;
  localparam int          FCSC_STAT_OK     = 1;
  // reset values
  localparam logic [7:0]  FCSC_CTRL_RST    = 8'h00;
  localparam logic [7:0]  FCSC_SRC_RST     = 8'h00;
  localparam logic [7:0]  FCSC_STATUS_RST  = 8'h02;
  // section encodings
  localparam logic [1:0]  FCSC_SEC_FLASH   = 2'h0;
  localparam logic [1:0]  FCSC_SEC_BOOT_AND_APP_SECTIONS = 2'h1;
  localparam logic [1:0]  FCSC_SEC_BOOT    = 2'h2;
  // checksum arithmetic
  localparam logic [15:0] FCSC_CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] FCSC_CRC_POLY    = 16'h1021;
  localparam logic [15:0] FCSC_CRC_GOOD    = 16'h0000;
  // timing counts in main clock cycles
  localparam logic [1:0]  FCSC_START_DLY   = 2'h3;
  localparam logic [1:0]  FCSC_FETCH_LAST  = 2'h2;
  // flash word address width
  localparam int          FCSC_FADDR_W     = 16;

  typedef enum logic [1:0] {
    FCSC_S_IDLE  = 2'b00,
    FCSC_S_DELAY = 2'b01,
    FCSC_S_SCAN  = 2'b11
  } fcsc_state_t;

  // one flash read request
  typedef struct packed {
    logic                    req;
    logic [FCSC_FADDR_W-1:0] addr;
  } fcsc_flash_req_t;
endpackage
`default_nettype wire

// *** fcsc_scanner_asserts.sv ***
// port assertions for the flash checksum scanner
`default_nettype none
module fcsc_scanner_asserts
  import fcsc_pkg::*;
(
  // clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   rst_i,
  // bus and processor side
  input wire logic                   avs_read_i,
  input wire logic                   avs_write_i,
  input wire logic [FCSC_DATA_W-1:0] avs_readdata_o,
  input wire logic                   avs_waitrequest_o,
  input wire logic                   sleep_i,
  input wire logic                   nmi_o,
  // flash side
  input wire fcsc_flash_req_t        flash_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // a request counts as new only after an idle cycle on the bus
  sequence s_new_req;
    (avs_read_i || avs_write_i) && !$past(avs_read_i || avs_write_i);
  endsequence
  sequence s_one_wait;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  chk_bus_one_wait: assert property (s_new_req |-> s_one_wait)
    else $error("bus wait not one cycle");
  chk_bus_idle_free: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("wait without request");
  chk_read_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_nmi_sticky: assert property (nmi_o |=> nmi_o)
    else $error("fault interrupt dropped");
  chk_nmi_after_reset: assert property ($fell(rst_i) |-> !nmi_o)
    else $error("fault interrupt survived reset");
  chk_fetch_third_cycle: assert property (flash_o.req |=> !flash_o.req [*2])
    else $error("fetches closer than three cycles");
  // req is registered, so two asleep samples are needed before it must be quiet
  chk_sleep_no_fetch: assert property (sleep_i ##1 sleep_i |-> !flash_o.req)
    else $error("fetch while asleep");
  // the interrupt only follows a checked word or a register write
  chk_nmi_has_cause: assert property ($rose(nmi_o) |-> $past(flash_o.req, 2) || $past(flash_o.req, 3) ||
    $past(flash_o.req, 4) || $past(flash_o.req, 5) || $past(avs_write_i) || $past(avs_write_i, 2))
    else $error("fault interrupt without cause");
endmodule
bind fcsc_scanner fcsc_scanner_asserts u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .sleep_i(sleep_i), .nmi_o(nmi_o), .flash_o(flash_o));
`default_nettype wire

// *** fcsc_flash_model.sv ***
// behavioural program flash answering scanner fetches in the cycle the request stands
`default_nettype none
module fcsc_flash_model
  import fcsc_pkg::*;
(
  // clock
  input  wire logic            clk_sys_i,
  // fetch request and corruption control
  input  wire fcsc_flash_req_t flash_i,
  input  wire logic            bad_i,
  // fetched word
  output logic [15:0]          rdata_o
);
  logic [15:0] mem [16];
  logic [15:0] c;
  function automatic logic [15:0] step(input logic [15:0] s, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) s = {s[14:0], 1'b0} ^ ((s[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return s;
  endfunction
  // sections end at words 5, 7 and 9; inner checksums feed the outer ones
  initial begin
    for (int w = 0; w < 16; w++) mem[w] = 16'h5A3C ^ (16'(w) * 16'h1357);
    for (int l = 5; l < 10; l += 2) begin
      c = 16'hFFFF;
      for (int w = 0; w < l; w++) c = step(step(c, mem[w][7:0]), mem[w][15:8]);
      mem[l] = {c[7:0], c[15:8]};
    end
  end
  // the scanner absorbs the word while its registered request stands, so data is
  // only valid then; otherwise a marker pattern shows any stale use
  always_comb begin
    if (flash_i.req) rdata_o = mem[flash_i.addr[3:0]] ^ {15'h0000, bad_i};
    else rdata_o = 16'hA5A5;
  end
endmodule
`default_nettype wire

// *** fcsc_scanner_tb.sv ***
// self-checking bench for the flash checksum scanner
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module fcsc_scanner_tb
  import fcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic            clk_sys_i = 1'b0;
  logic            rst_i = 1'b1;
  logic [3:0]      avs_address_i = 4'h0;
  logic            avs_read_i = 1'b0, avs_write_i = 1'b0, dbg_write_i = 1'b0;
  logic [31:0]     avs_writedata_i = 32'h0, avs_readdata_o, q;
  logic            dbg_access_i = 1'b0, dbg_internal_i = 1'b0, dbg_disconnect_i = 1'b0;
  logic            sleep_i = 1'b0, startup_load_i = 1'b0, startup_ok_i = 1'b0, bad = 1'b0;
  logic [1:0]      startup_src_i = 2'h0;
  logic            avs_waitrequest_o, cpu_stall_o, irq_defer_o, nmi_o;
  fcsc_flash_req_t flash_o;
  logic [15:0]     flash_rdata_i, nxt = 16'h0;
  int              nreq = 0, fail_count = 0, n_compared = 0;
  fcsc_scanner uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .dbg_write_i(dbg_write_i),
    .dbg_access_i(dbg_access_i), .dbg_internal_i(dbg_internal_i), .dbg_disconnect_i(dbg_disconnect_i),
    .sleep_i(sleep_i), .cpu_stall_o(cpu_stall_o), .irq_defer_o(irq_defer_o), .nmi_o(nmi_o),
    .startup_load_i(startup_load_i), .startup_src_i(startup_src_i), .startup_ok_i(startup_ok_i),
    .flash_last_i(16'h0009), .app_last_i(16'h0007), .boot_last_i(16'h0005), .flash_o(flash_o),
    .flash_rdata_i(flash_rdata_i));
  fcsc_flash_model u_flash (.clk_sys_i(clk_sys_i), .flash_i(flash_o), .bad_i(bad), .rdata_o(flash_rdata_i));
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  // fetches must ascend from word zero; nxt is rewound only while no fetch is due
  always @(posedge clk_sys_i) begin
    if (flash_o.req === 1'b1) begin
      `CHK(flash_o.addr, nxt)
      nxt = nxt + 16'h0001;
      nreq++;
    end
  end
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic dbg);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= {24'h000000, d};
    dbg_write_i <= dbg;
    do begin @(posedge clk_sys_i); n++; end while (avs_waitrequest_o !== 1'b0 && n < 50);
    `CHK(n < 50, 1'b1)
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    dbg_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b0);
    `CHK(q[7:0], e)
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  // poll status until busy drops, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin bus(1'b0, 4'h8, 8'h00, 1'b0); n++; end while (q[0] !== 1'b0 && n < 100);
    `CHK(n < 100, 1'b1)
  endtask
  task automatic fin(input string s);
    $display("test %s ended, mismatches %0d", s, fail_count);
  endtask
  task automatic final_report();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    tick(2);
    rst_i <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h02);
    rd(4'h1, 8'h00);
    wr(4'h8, 8'h00);
    rd(4'h8, 8'h02);
    fin("reset");
    // one pass per section; section and interrupt enable writes during the pass are refused
    for (int s = 0; s < 3; s++) begin
      wr(4'h4, 8'(s));
      nxt = 16'h0000;
      nreq = 0;
      wr(4'h0, 8'h01);
      rd(4'h8, 8'h01);
      wr(4'h0, 8'h02);
      wr(4'h4, 8'h03);
      rd(4'h0, 8'h00);
      wait_idle();
      rd(4'h8, 8'h02);
      rd(4'h4, 8'(s));
      `CHK(nreq, 10 - 2 * s)
    end
    fin("sections");
    nxt = 16'h0000;
    nreq = 0;
    wr(4'h0, 8'h01);
    sleep_i <= 1'b1;
    tick(20);
    `CHK(irq_defer_o, 1'b1)
    `CHK(nreq, 0)
    wr(4'h0, 8'h00);
    sleep_i <= 1'b0;
    wait_idle();
    `CHK(nreq, 6)
    `CHK(irq_defer_o, 1'b0)
    fin("sleep");
    // debugger hold mid-scan, then restart from word zero on disconnect
    nxt = 16'h0000;
    wr(4'h0, 8'h01);
    tick(8);
    `CHK(cpu_stall_o, 1'b1)
    dbg_access_i <= 1'b1;
    tick(1);
    dbg_access_i <= 1'b0;
    tick(2);
    nreq = 0;
    tick(15);
    `CHK(nreq, 0)
    `CHK(cpu_stall_o, 1'b0)
    rd(4'h8, 8'h01);
    nxt = 16'h0000;
    dbg_disconnect_i <= 1'b1;
    tick(1);
    dbg_disconnect_i <= 1'b0;
    wr(4'h0, 8'h00);
    wait_idle();
    `CHK(nreq, 6)
    fin("debug hold");
    // debugger abort, then a single debugger-started check
    nxt = 16'h0000;
    wr(4'h0, 8'h01);
    tick(6);
    dbg_access_i <= 1'b1;
    tick(1);
    dbg_access_i <= 1'b0;
    bus(1'b1, 4'h8, 8'h00, 1'b1);
    dbg_internal_i <= 1'b1;
    tick(1);
    dbg_internal_i <= 1'b0;
    nreq = 0;
    tick(20);
    `CHK(nreq, 0)
    rd(4'h8, 8'h00);
    wr(4'h0, 8'h00);
    nxt = 16'h0000;
    bus(1'b1, 4'h8, 8'h01, 1'b1);
    wait_idle();
    `CHK(nreq, 6)
    rd(4'h8, 8'h02);
    fin("debug abort");
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h8, 8'h00);
    fin("strobe");
    // failing final pass with the fault interrupt enabled
    wr(4'h0, 8'h02);
    rd(4'h0, 8'h02);
    bad = 1'b1;
    nxt = 16'h0000;
    wr(4'h0, 8'h03);
    wr(4'h0, 8'h02);
    wait_idle();
    rd(4'h8, 8'h00);
    `CHK(nmi_o, 1'b1)
    wr(4'h0, 8'h81);
    rd(4'h0, 8'h02);
    wr(4'h4, 8'h01);
    rd(4'h4, 8'h00);
    `CHK(nmi_o, 1'b1)
    bad = 1'b0;
    rst_i <= 1'b1;
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    `CHK(nmi_o, 1'b0)
    fin("fault");
    startup_src_i <= 2'h1;
    startup_ok_i <= 1'b1;
    startup_load_i <= 1'b1;
    tick(1);
    startup_load_i <= 1'b0;
    rd(4'h0, 8'h01);
    rd(4'h4, 8'h01);
    bus(1'b1, 4'h8, 8'h00, 1'b1);
    rd(4'h8, 8'h00);
    bus(1'b1, 4'h8, 8'h02, 1'b1);
    rd(4'h8, 8'h02);
    wr(4'h0, 8'h02);
    bus(1'b1, 4'h8, 8'h00, 1'b1);
    tick(2);
    `CHK(nmi_o, 1'b1)
    fin("startup and debugger flags");
    final_report();
  end
  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    tick(20000);
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire
